// File: bench/ethernet_interrupt_status_enable_tb_top.sv
// Self-checking bench for the interrupt event flags and source mask.
// Assumes the host model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module ethernet_interrupt_status_enable_tb_top;
  import irq_status_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ack, master_irq, irq_out, holdoff, low_power;
  logic [31:0] dat_o;
  logic [31:0] q;
  bus_request_type req;
  event_sources_type ev = '0;
  int miscompares = 0;
  int num_checks = 0;
  int bits [25] = '{17, 16, 14, 13, 6, 0, 1, 2, 24, 25, -1, 8, 7, 4, 3, 18, 21, 23, -1,
                    19, 15, -1, 10, 9, 20};
  always #2.5 clk = ~clk;
  irq_status_top dut_u (.CLK(clk), .SYS_RST(sys_rst), .BUS_REQ(req), .BUS_DAT_O(dat_o),
    .BUS_ACK(ack), .EVENTS(ev), .MASTER_IRQ(master_irq), .IRQ_OUT(irq_out),
    .HOLDOFF_PENDING(holdoff), .LOW_POWER(low_power));
  wb_host_model host_u (.clk(clk), .dat_i(dat_o), .ack(ack), .req(req));
  function automatic event_sources_type stim(input int k);
    event_sources_type e;
    e = '0;
    e.tx_halt_requested = (k == 9);
    e.completion_notify_flag = (k == 16);
    e.drop_count = (k == 17) ? 32'h7FFF_FFFF : 32'h7FFF_FFFE;
    e.timer_count = (k == 19) ? 16'h0000 : 16'h0001;
    e.frame_length = (k == 20) ? 14'd2049 : 14'd2048;
    e.tx_free_bytes = (k == 23) ? 14'd4609 : 14'd4608;
    e.tx_data_full = (k == 22);
    case (k)
      0: e.power_event = 1'b1;
      1: e.tx_status_overflow = 1'b1;
      2: e.rx_error = 1'b1;
      3: e.tx_error = 1'b1;
      4: e.frame_dropped = 1'b1;
      5, 6, 7: e.pin_events[k - 5] = 1'b1;
      8: e.rx_halted = 1'b1;
      9, 10: e.tx_halted = 1'b1;
      11: e.tx_status_full = 1'b1;
      12: e.tx_status_level = 1'b1;
      13: e.rx_status_full = 1'b1;
      14: e.rx_status_level = 1'b1;
      15: e.transceiver_irq = 1'b1;
      16: e.buffer_loaded = 1'b1;
      17, 18: e.drop_count_inc = 1'b1;
      19: e.timer_dec = 1'b1;
      20, 21: e.frame_end = 1'b1;
      22: e.tx_data_write = 1'b1;
      24: e.rx_word_read = 1'b1;
      default: ;
    endcase
    return e;
  endfunction : stim
  task automatic check32(input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, e);
    end
  endtask : check32
  task automatic check1(input logic got, input logic e);
    num_checks++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag %b want %b", $time, got, e);
    end
  endtask : check1
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    host_u.access(1'b1, a, s, d, q);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    host_u.access(1'b0, a, 4'hF, 32'h0, q);
    check32(q, e);
  endtask : rdchk
  task automatic pulse(input int k);
    ev <= stim(k);
    @(posedge clk);
    ev <= '0;
  endtask : pulse
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // About twenty-five times the expected run length
  initial begin
    #50us;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdchk(STATUS_OFFSET, STATUS_RESET);
    rdchk(MASK_OFFSET, MASK_RESET);
    wr(MASK_OFFSET, 4'hF, 32'hFFFF_FFFF);
    rdchk(MASK_OFFSET, IMPLEMENTED_MASK);
    rdchk(STATUS_OFFSET, 32'h8000_0000);
    wr(STATUS_OFFSET, 4'hF, 32'h8000_0000);
    rdchk(STATUS_OFFSET, 32'h0);
    wr(THRESHOLD_OFFSET, 4'h2, 32'h0000_0100);
    for (int k = 0; k < 25; k++) begin
      // Held two edges: the flag sets on the first, the registered master line on the second
      ev <= stim(k);
      repeat (2) @(posedge clk);
      rdchk(STATUS_OFFSET, (bits[k] < 0) ? 32'h0 : 32'h1 << bits[k]);
      check1(master_irq, bits[k] >= 0);
      ev <= '0;
      @(posedge clk);
      wr(STATUS_OFFSET, 4'hF, 32'hFFFF_FFFF);
      rdchk(STATUS_OFFSET, 32'h0);
      check1(master_irq, 1'b0);
      $display("row %0d done", k);
    end
    wr(MASK_OFFSET, 4'hF, 32'h0);
    pulse(2);
    rdchk(STATUS_OFFSET, 32'h0000_4000);
    check1(master_irq, 1'b0);
    wr(MASK_OFFSET, 4'hF, 32'h0000_4000);
    wr(CONTROL_OFFSET, 4'h2, 32'h0000_0100);
    rdchk(CONTROL_OFFSET, 32'h0000_1100);
    check1(irq_out, 1'b1);
    wr(CONTROL_OFFSET, 4'h2, 32'h0);
    rdchk(CONTROL_OFFSET, 32'h0000_1000);
    check1(irq_out, 1'b0);
    $display("mask and output test done");
    fork
      wr(STATUS_OFFSET, 4'hF, 32'hFFFF_FFFF);
      pulse(0);
    join
    rdchk(STATUS_OFFSET, 32'h0002_0000);
    wr(STATUS_OFFSET, 4'hF, 32'h0);
    rdchk(STATUS_OFFSET, 32'h0002_0000);
    wr(MASK_OFFSET, 4'hF, 32'h0002_0000);
    rdchk(8'h40, 32'h0);
    check1(master_irq, 1'b1);
    check1(holdoff, 1'b0);
    wr(MASK_OFFSET, 4'hF, 32'h8002_0000);
    check1(holdoff, 1'b1);
    $display("set priority test done");
    wr(STATUS_OFFSET, 4'hF, 32'hFFFF_FFFF);
    wr(CONTROL_OFFSET, 4'hF, 32'h0000_0001);
    pulse(0);
    rdchk(STATUS_OFFSET, 32'h0002_0000);
    check1(low_power, 1'b1);
    wr(8'h40, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h40, 32'h0);
    check1(low_power, 1'b1);
    wr(WAKE_OFFSET, 4'hF, 32'h1234_5678);
    check1(low_power, 1'b0);
    $display("power test done");
    conclude();
  end
endmodule : ethernet_interrupt_status_enable_tb_top
`default_nettype wire

// File: bench/irq_status_assertions.sv
// Port checker for the interrupt event flags and source mask block.
// Assumes writes land at the edge that takes the request.
`timescale 1ns/10ps
`default_nettype none
module irq_status_checker (
  input wire logic                              CLK,
  input wire logic                              SYS_RST,
  input wire irq_status_pkg::bus_request_type   BUS_REQ,
  input wire logic [31:0]                       BUS_DAT_O,
  input wire logic                              BUS_ACK,
  input wire irq_status_pkg::event_sources_type EVENTS,
  input wire logic                              MASTER_IRQ,
  input wire logic                              IRQ_OUT,
  input wire logic                              HOLDOFF_PENDING,
  input wire logic                              LOW_POWER
);
  import irq_status_pkg::*;
  logic        take;
  logic        wake_wr;
  logic [31:0] pulses;
  logic [31:0] mask_reg;
  logic        oe_reg;
  assign take = BUS_REQ.cyc && BUS_REQ.stb && !BUS_ACK;
  assign wake_wr = take && BUS_REQ.we && BUS_REQ.adr == WAKE_OFFSET;
  assign pulses = {14'h0, EVENTS.power_event, EVENTS.tx_status_overflow, 1'b0,
                   EVENTS.rx_error, EVENTS.tx_error, 6'h0, EVENTS.frame_dropped,
                   3'h0, EVENTS.pin_events};
  // Shadow copies, so master and output can be tied to host writes
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_reg <= MASK_RESET;
      oe_reg   <= 1'b0;
    end else if (take && BUS_REQ.we) begin
      for (int i = 0; i < 4; i++) begin
        if (BUS_REQ.adr == MASK_OFFSET && BUS_REQ.sel[i]) begin
          mask_reg[8*i +: 8] <= BUS_REQ.dat[8*i +: 8] & IMPLEMENTED_MASK[8*i +: 8];
        end
      end
      if (BUS_REQ.adr == CONTROL_OFFSET && BUS_REQ.sel[1]) begin
        oe_reg <= BUS_REQ.dat[CONTROL_OUT_EN];
      end
    end
  end
  default clocking main_cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_ack_one_pulse: assert property (take |=> BUS_ACK ##1 !BUS_ACK)
    else $error("ack not a single pulse");
  a_mask_blocks_all: assert property (mask_reg == 32'h0 |=> !MASTER_IRQ)
    else $error("master raised with empty mask");
  a_pulse_raises_master: assert property (|(pulses & mask_reg) |-> ##2 MASTER_IRQ)
    else $error("enabled event did not raise master");
  a_out_held_off: assert property (!oe_reg |=> !IRQ_OUT)
    else $error("output active while disabled");
  a_out_follows_master: assert property (oe_reg |=> IRQ_OUT == MASTER_IRQ)
    else $error("output differs from master");
  a_power_no_holdoff: assert property ((mask_reg & 32'hFFFD_FFFF) == 32'h0 |=> !HOLDOFF_PENDING)
    else $error("power source entered holdoff");
  // Output lags the power-down state by one register stage
  a_wake_on_write: assert property (wake_wr |-> ##2 !LOW_POWER)
    else $error("no wake after test register write");
  a_stay_asleep: assert property (LOW_POWER && !wake_wr && !$past(wake_wr) |=> LOW_POWER)
    else $error("left low power without write");
  a_unmapped_reads_zero: assert property (take && !BUS_REQ.we && BUS_REQ.adr == 8'h40 |=> BUS_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  c_irq_out: cover property (IRQ_OUT);
  c_sleep_wake: cover property (LOW_POWER ##1 !LOW_POWER);
  c_master_gated: cover property (MASTER_IRQ && !IRQ_OUT);
endmodule : irq_status_checker
bind irq_status_top irq_status_checker chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .BUS_REQ(BUS_REQ),
  .BUS_DAT_O(BUS_DAT_O), .BUS_ACK(BUS_ACK), .EVENTS(EVENTS), .MASTER_IRQ(MASTER_IRQ),
  .IRQ_OUT(IRQ_OUT), .HOLDOFF_PENDING(HOLDOFF_PENDING), .LOW_POWER(LOW_POWER));
`default_nettype wire

// File: bench/wb_host_model.sv
// Host processor model issuing classic Wishbone single cycles.
// Assumes the slave answers with a one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
module wb_host_model (
  input  wire logic                            clk,
  input  wire logic [31:0]                     dat_i,
  input  wire logic                            ack,
  output var  irq_status_pkg::bus_request_type req
);
  import irq_status_pkg::*;
  initial req = '0;
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    // A lost answer returns unknown data so the compare fails
    q = (ack === 1'b1) ? dat_i : 'x;
    // Released lines carry inverted values, never the stale request
    req <= '{cyc: 1'b0, stb: 1'b0, we: ~w, adr: ~a, sel: ~s, dat: ~d};
    @(posedge clk);
  endtask : access
endmodule : wb_host_model
`default_nettype wire

// File: logic/event_edge_detect.sv
// Rising-edge detector for level-type event sources.
// Assumes sources are synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
module event_edge_detect (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  level_in,
  output logic      [7:0]  rise_pulse
);
  import irq_status_pkg::*;

  logic [7:0] level_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_reg <= 8'h00;
    end else begin
      level_reg <= level_in;
    end
  end

  assign rise_pulse = level_in & ~level_reg;
endmodule : event_edge_detect
`default_nettype wire

// File: logic/irq_status_pkg.sv
// Shared constants and carriers for the interrupt event and mask block.
// Assumes a 32-bit classic Wishbone register bus and one 200 MHz clock.
package irq_status_pkg;

  localparam logic [7:0]  STATUS_OFFSET     = 8'h58;
  localparam logic [7:0]  MASK_OFFSET       = 8'h5C;
  localparam logic [7:0]  CONTROL_OFFSET    = 8'h60;
  localparam logic [7:0]  WAKE_OFFSET       = 8'h64;
  localparam logic [7:0]  THRESHOLD_OFFSET  = 8'h68;

  localparam int SOFTWARE_BIT     = 31;
  localparam int TX_HALT_BIT      = 25;
  localparam int RX_HALT_BIT      = 24;
  localparam int DROP_MID_BIT     = 23;
  localparam int LOADED_BIT       = 21;
  localparam int RX_COUNT_BIT     = 20;
  localparam int TIMER_WRAP_BIT   = 19;
  localparam int TRANSCEIVER_BIT  = 18;
  localparam int POWER_BIT        = 17;
  localparam int TX_STAT_OVF_BIT  = 16;
  localparam int OVERSIZE_BIT     = 15;
  localparam int RX_ERROR_BIT     = 14;
  localparam int TX_ERROR_BIT     = 13;
  localparam int TX_OVERRUN_BIT   = 10;
  localparam int TX_SPACE_BIT     = 9;
  localparam int TX_STAT_FULL_BIT = 8;
  localparam int TX_STAT_LVL_BIT  = 7;
  localparam int DROPPED_BIT      = 6;
  localparam int RX_STAT_FULL_BIT = 4;
  localparam int RX_STAT_LVL_BIT  = 3;

  // Implemented status and mask bits; all others are reserved
  localparam logic [31:0] IMPLEMENTED_MASK  = 32'h83BF_E7DF;
  localparam logic [31:0] MASK_RESET        = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET      = 32'h0000_0000;
  localparam logic [31:0] DROP_MIDPOINT     = 32'h8000_0000;
  localparam logic [15:0] TIMER_WRAP_VALUE  = 16'hFFFF;
  localparam logic [7:0]  SPACE_LEVEL_RESET = 8'h48;
  localparam int          SPACE_BLOCK_BYTES = 64;
  localparam int          OVERSIZE_BYTES    = 2048;
  localparam int          LENGTH_WIDTH      = 14;
  localparam int          SPACE_WIDTH       = 14;
  localparam int          CONTROL_OUT_EN    = 8;
  localparam int          CONTROL_MASTER    = 12;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bus_request_type;

  typedef struct packed {
    logic        tx_halt_requested;
    logic        tx_halted;
    logic        rx_halted;
    logic        drop_count_inc;
    logic [31:0] drop_count;
    logic        buffer_loaded;
    logic        completion_notify_flag;
    logic        rx_word_read;
    logic        timer_dec;
    logic [15:0] timer_count;
    logic        transceiver_irq;
    logic        power_event;
    logic        tx_status_overflow;
    logic        frame_end;
    logic [13:0] frame_length;
    logic        rx_error;
    logic        tx_error;
    logic        tx_data_write;
    logic        tx_data_full;
    logic [13:0] tx_free_bytes;
    logic        tx_status_full;
    logic        tx_status_level;
    logic        frame_dropped;
    logic        rx_status_full;
    logic        rx_status_level;
    logic [2:0]  pin_events;
  } event_sources_type;

endpackage : irq_status_pkg

// File: logic/irq_status_top.sv
// Interrupt event flags, source mask and master request for the controller.
// Assumes a classic Wishbone master and event sources synchronous to CLK.
// Function
// RULE_01: Status register, write one clears bit.
// RULE_02: Software flag set by its enable bit.
// RULE_03: Transmit halted flag after requested stop.
// RULE_04: Receive halted flag when receiver stops.
// RULE_05: Drop counter reaching midpoint sets flag.
// RULE_06: Completed notify buffer load sets flag.
// RULE_07: Receive transfer count drained sets flag.
// RULE_08: Timer wrap to all ones sets flag.
// RULE_09: Transceiver bit mirrors input, writes ignored.
// RULE_10: Power event flag independent of wake signal.
// RULE_11: Wake only on write to test register.
// RULE_12: Power flag bypasses holdoff interval.
// RULE_13: Transmit status overflow sets flag.
// RULE_14: Frame above 2048 bytes sets flag.
// RULE_15: Receive and transmit errors set flags.
// RULE_16: Write to full transmit data FIFO.
// RULE_17: Transmit free space above threshold sets flag.
// RULE_18: Status FIFOs full set their flags.
// RULE_19: Status FIFOs at level set flags.
// RULE_20: Each dropped frame sets flag.
// RULE_21: Pin events set three low flags.
// RULE_22: Mask admits flags; flags record regardless.
// RULE_23: Master line is any flag with mask.
// RULE_24: Output enable clear holds output inactive.
// RULE_25: Space threshold counted in 64-byte blocks.
// RULE_26: Flags stay set; set beats clear.
// RULE_27: Reserved bits read zero, ignore writes.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module irq_status_top (
  input  wire logic                              CLK,
  input  wire logic                              SYS_RST,
  input  wire irq_status_pkg::bus_request_type   BUS_REQ,
  output var  logic [31:0]                       BUS_DAT_O,
  output var  logic                              BUS_ACK,
  input  wire irq_status_pkg::event_sources_type EVENTS,
  output var  logic                              MASTER_IRQ,
  output var  logic                              IRQ_OUT,
  output var  logic                              HOLDOFF_PENDING,
  output var  logic                              LOW_POWER
);
  import irq_status_pkg::*;

  logic [31:0] flags_reg;
  logic [31:0] mask_reg;
  logic        out_enable_reg;
  logic [7:0]  space_level_reg;
  logic [11:0] transfer_count_reg;
  logic        sleep_request_reg;
  logic        power_down_reg;
  logic [31:0] set_pulse;
  logic [31:0] clear_pulse;
  logic [31:0] flags_view;
  logic [7:0]  level_in;
  logic [7:0]  rise_pulse;
  logic        access;
  logic        write_hit;
  logic [31:0] write_data;
  logic [31:0] read_next;
  logic        any_active;
  logic        space_above;
  logic        holdoff_reg;

  sticky_flag_bank u_flags (
    .clk         (CLK),
    .rst         (SYS_RST),
    .set_pulse   (set_pulse),
    .clear_pulse (clear_pulse),
    .flags_reg   (flags_reg)
  );

  event_edge_detect u_edges (
    .clk        (CLK),
    .rst        (SYS_RST),
    .level_in   (level_in),
    .rise_pulse (rise_pulse)
  );

  // Bus decode: one cycle answer, ack dropped after each beat
  assign access    = BUS_REQ.cyc && BUS_REQ.stb && !BUS_ACK;
  assign write_hit = access && BUS_REQ.we;

  always_comb begin
    write_data = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (BUS_REQ.sel[b]) begin
        write_data[8*b +: 8] = BUS_REQ.dat[8*b +: 8];
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BUS_ACK <= 1'b0;
    end else begin
      BUS_ACK <= access;
    end
  end

  // Level sources turn into single events on their rising edge
  assign space_above = EVENTS.tx_free_bytes >
    (SPACE_WIDTH'(space_level_reg) * SPACE_WIDTH'(SPACE_BLOCK_BYTES)); // RULE_25
  assign level_in = {EVENTS.tx_halt_requested && EVENTS.tx_halted, // RULE_03
                     EVENTS.rx_halted,                              // RULE_04
                     space_above,                                   // RULE_17
                     EVENTS.tx_status_full,                         // RULE_18
                     EVENTS.rx_status_full,                         // RULE_18
                     EVENTS.tx_status_level,                        // RULE_19
                     EVENTS.rx_status_level,                        // RULE_19
                     1'b0};

  // Receive transfer countdown, reloadable by software
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      transfer_count_reg <= 12'h000;
    end else if (write_hit && BUS_REQ.adr == THRESHOLD_OFFSET && BUS_REQ.sel[1]) begin
      transfer_count_reg <= {4'h0, write_data[15:8]};
    end else if (EVENTS.rx_word_read && transfer_count_reg != 12'h000) begin
      transfer_count_reg <= transfer_count_reg - 12'h001;
    end
  end

  always_comb begin
    set_pulse                   = 32'h0000_0000;
    set_pulse[SOFTWARE_BIT]     = write_hit && BUS_REQ.adr == MASK_OFFSET
                                  && BUS_REQ.sel[3] && write_data[SOFTWARE_BIT]
                                  && !mask_reg[SOFTWARE_BIT];       // RULE_02
    set_pulse[TX_HALT_BIT]      = rise_pulse[7];                    // RULE_03
    set_pulse[RX_HALT_BIT]      = rise_pulse[6];                    // RULE_04
    set_pulse[DROP_MID_BIT]     = EVENTS.drop_count_inc
                                  && EVENTS.drop_count == DROP_MIDPOINT - 32'h0000_0001; // RULE_05
    set_pulse[LOADED_BIT]       = EVENTS.buffer_loaded
                                  && EVENTS.completion_notify_flag; // RULE_06
    set_pulse[RX_COUNT_BIT]     = EVENTS.rx_word_read
                                  && transfer_count_reg == 12'h001; // RULE_07
    set_pulse[TIMER_WRAP_BIT]   = EVENTS.timer_dec
                                  && EVENTS.timer_count == ~TIMER_WRAP_VALUE; // RULE_08
    set_pulse[POWER_BIT]        = EVENTS.power_event;               // RULE_10
    set_pulse[TX_STAT_OVF_BIT]  = EVENTS.tx_status_overflow;        // RULE_13
    set_pulse[OVERSIZE_BIT]     = EVENTS.frame_end
      && EVENTS.frame_length > LENGTH_WIDTH'(OVERSIZE_BYTES);       // RULE_14
    set_pulse[RX_ERROR_BIT]     = EVENTS.rx_error;                  // RULE_15
    set_pulse[TX_ERROR_BIT]     = EVENTS.tx_error;                  // RULE_15
    set_pulse[TX_OVERRUN_BIT]   = EVENTS.tx_data_write
                                  && EVENTS.tx_data_full;           // RULE_16
    set_pulse[TX_SPACE_BIT]     = rise_pulse[5];                    // RULE_17
    set_pulse[TX_STAT_FULL_BIT] = rise_pulse[4];                    // RULE_18
    set_pulse[RX_STAT_FULL_BIT] = rise_pulse[3];                    // RULE_18
    set_pulse[TX_STAT_LVL_BIT]  = rise_pulse[2];                    // RULE_19
    set_pulse[RX_STAT_LVL_BIT]  = rise_pulse[1];                    // RULE_19
    set_pulse[DROPPED_BIT]      = EVENTS.frame_dropped;             // RULE_20
    set_pulse[2:0]              = EVENTS.pin_events;                // RULE_21
  end

  // Clear only implemented bits; the mirrored bit ignores writes
  assign clear_pulse = (write_hit && BUS_REQ.adr == STATUS_OFFSET)
                       ? (write_data & IMPLEMENTED_MASK) : 32'h0000_0000; // RULE_01

  always_comb begin
    flags_view                  = flags_reg;
    flags_view[TRANSCEIVER_BIT] = EVENTS.transceiver_irq; // RULE_09
  end

  // Mask register, reserved bits forced low
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_reg <= MASK_RESET;
    end else if (write_hit && BUS_REQ.adr == MASK_OFFSET) begin
      for (int b = 0; b < 4; b++) begin
        if (BUS_REQ.sel[b]) begin
          mask_reg[8*b +: 8] <= BUS_REQ.dat[8*b +: 8] & IMPLEMENTED_MASK[8*b +: 8]; // RULE_27
        end
      end
    end
  end

  // Control and threshold words
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_enable_reg  <= 1'b0;
      space_level_reg <= SPACE_LEVEL_RESET;
    end else if (write_hit) begin
      if (BUS_REQ.adr == CONTROL_OFFSET && BUS_REQ.sel[1]) begin
        out_enable_reg <= BUS_REQ.dat[CONTROL_OUT_EN];
      end
      if (BUS_REQ.adr == THRESHOLD_OFFSET && BUS_REQ.sel[3]) begin
        space_level_reg <= BUS_REQ.dat[31:24];
      end
    end
  end

  // Power-down: entered by software, left only on a test register write
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sleep_request_reg <= 1'b0;
    end else if (write_hit && BUS_REQ.adr == CONTROL_OFFSET && BUS_REQ.sel[0]) begin
      sleep_request_reg <= BUS_REQ.dat[0];
    end else begin
      sleep_request_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      power_down_reg <= 1'b0;
    end else if (write_hit && BUS_REQ.adr == WAKE_OFFSET) begin
      power_down_reg <= 1'b0; // RULE_11
    end else if (sleep_request_reg) begin
      power_down_reg <= 1'b1; // RULE_11
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LOW_POWER <= 1'b0;
    end else begin
      LOW_POWER <= power_down_reg;
    end
  end

  // Master line and gated output
  assign any_active = |(flags_view & mask_reg); // RULE_22

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MASTER_IRQ <= 1'b0;
    end else begin
      MASTER_IRQ <= any_active; // RULE_23
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= out_enable_reg && any_active; // RULE_24
    end
  end

  // Power sources need no holdoff; others may be held off outside
  assign holdoff_reg = |(flags_view & mask_reg & ~(32'h0000_0001 << POWER_BIT));

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HOLDOFF_PENDING <= 1'b0;
    end else begin
      HOLDOFF_PENDING <= holdoff_reg; // RULE_12
    end
  end

  // Read mux; unmapped reads return zero but still ack
  always_comb begin
    read_next = 32'h0000_0000;
    unique case (BUS_REQ.adr)
      STATUS_OFFSET:    read_next = flags_view & IMPLEMENTED_MASK;
      MASK_OFFSET:      read_next = mask_reg;
      CONTROL_OFFSET:   read_next = {19'h0_0000, MASTER_IRQ, 3'h0, out_enable_reg, 8'h00};
      WAKE_OFFSET:      read_next = {31'h0000_0000, power_down_reg};
      THRESHOLD_OFFSET: read_next = {space_level_reg, 8'h00, 4'h0, transfer_count_reg[11:8],
                                     transfer_count_reg[7:0]};
      default:          read_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BUS_DAT_O <= 32'h0000_0000;
    end else if (access && !BUS_REQ.we) begin
      BUS_DAT_O <= read_next;
    end
  end
endmodule : irq_status_top
`default_nettype wire

// File: logic/sticky_flag_bank.sv
// Bank of sticky event flags with write-one-to-clear.
// Assumes single-cycle event and clear pulses on CLK.
`timescale 1ns/10ps
`default_nettype none
module sticky_flag_bank (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] set_pulse,
  input  wire logic [31:0] clear_pulse,
  output var  logic [31:0] flags_reg
);
  import irq_status_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_flag
      if (IMPLEMENTED_MASK[i] && i != TRANSCEIVER_BIT) begin : g_live
        // Set beats clear so a coincident event survives
        always_ff @(posedge clk or posedge rst) begin
          if (rst) begin
            flags_reg[i] <= STATUS_RESET[i];
          end else if (set_pulse[i]) begin
            flags_reg[i] <= 1'b1; // RULE_26
          end else if (clear_pulse[i]) begin
            flags_reg[i] <= 1'b0; // RULE_01
          end
        end
      end else begin : g_fixed
        // Reserved and mirrored positions hold no state here
        always_ff @(posedge clk or posedge rst) begin
          if (rst) begin
            flags_reg[i] <= 1'b0;
          end else begin
            flags_reg[i] <= 1'b0; // RULE_27
          end
        end
      end
    end
  endgenerate
endmodule : sticky_flag_bank
`default_nettype wire
